// File: hw/twp_cfg.svh
/*
 * timer unit constants: register addresses, field positions, reset values, counts.
 * assumes inclusion by bare name from the package and bench files.
 */
`ifndef TWP_CFG_SVH
`define TWP_CFG_SVH

// register addresses on the core's special-register port
`define TWP_ADDR_FAST_CNT    8'h01
`define TWP_ADDR_PER_CTRL    8'h0c
`define TWP_ADDR_PWR_CTRL    8'h0e
`define TWP_ADDR_IRQ_MASK    8'h0f
`define TWP_ADDR_PER_CNT     8'h10
`define TWP_ADDR_PER_LIMIT   8'h11
`define TWP_ADDR_IRQ_FLAG    8'h3f
// field positions
`define TWP_POWER_CONTROL_WDT_EN      5
`define TWP_OPT_ASSIGN       3
`define TWP_PER_RUN          2
`define TWP_FLAG_FAST        0
`define TWP_FLAG_PERIOD      3
// reset values and power control write mask
`define TWP_OPTION_RST       8'hbf
`define TWP_PRESCALE_RST     8'hff
`define TWP_POWER_CONTROL_RST         8'h10
`define TWP_POWER_CONTROL_RMASK       8'he9
// timing
`define TWP_WDT_TIMEOUT_US   18000
`define TWP_WDT_RC_KHZ       1000
`define TWP_FAST_HOLD_CYC    2

`endif

// File: hw/twp_pkg.sv
/*
 * timer unit package: shared types.
 * assumes twp_cfg.svh is on the include path.
 */
`include "twp_cfg.svh"
package twp_pkg;
  typedef logic [7:0] twp_byte_t;  // one register byte
  typedef enum logic [1:0] {
    TWP_WD_RUN  = 2'b01,           // counting
    TWP_WD_FIRE = 2'b10            // timeout pulse sent
  } twp_wd_e;
endpackage

// File: hw/twp_wdt_core.sv
/*
 * watchdog counter on its own rc oscillator clock.
 * assumes clear requests arrive as a toggle and the timeout leaves as a toggle.
 */
`timescale 1ns/1ps
`default_nettype none
module twp_wdt_core
  import twp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `TWP_WDT_TIMEOUT_US * `TWP_WDT_RC_KHZ / 1000
) (
  // rc clock and reset
  input  wire logic i_clk_rc,
  input  wire logic i_reset_n,
  // control from instruction domain
  input  wire logic i_enable,       // already stable level, synchronised here
  input  wire logic i_clr_tgl,      // clear request toggle
  // event out
  output logic      o_tick_tgl      // base timeout toggle
);
  import twp_pkg::*;
  logic [1:0]  en_sync_q;           // enable synchroniser
  logic [2:0]  clr_sync_q;          // toggle synchroniser plus edge stage
  logic [31:0] cnt_q;               // base period counter
  twp_wd_e     st_q;                // run or fire

  // bring control across; stage 0 only feeds stage 1
  always_ff @(posedge i_clk_rc) begin
    if (!i_reset_n) begin
      en_sync_q  <= 2'b00;
      clr_sync_q <= 3'b000;
    end else begin
      en_sync_q  <= {en_sync_q[0], i_enable};
      clr_sync_q <= {clr_sync_q[1:0], i_clr_tgl};
    end
  end

  // count only while enabled, keeps going when core clock stops
  always_ff @(posedge i_clk_rc) begin
    if (!i_reset_n) begin
      cnt_q      <= 32'h0;
      st_q       <= TWP_WD_RUN;
      o_tick_tgl <= 1'b0;
    end else if (!en_sync_q[1] || (clr_sync_q[2] ^ clr_sync_q[1])) begin
      cnt_q <= 32'h0;
      st_q  <= TWP_WD_RUN;
    end else begin
      case (st_q)
        TWP_WD_RUN: begin
          if (cnt_q == TIMEOUT_CYC - 1) begin
            cnt_q      <= 32'h0;
            o_tick_tgl <= ~o_tick_tgl;
            st_q       <= TWP_WD_FIRE;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        TWP_WD_FIRE: st_q <= TWP_WD_RUN;
        default:     st_q <= TWP_WD_RUN;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: hw/twp_timer_unit.sv
/*
 * timer unit: fast timer, shared prescaler, watchdog, period timer, irq mask.
 * assumes core register port strobes are single cycle and synchronous to i_clk_sys.
 */
// Contract
// - watchdog runs only while enable bit set
// - fast timer counts each cycle without prescaler
// - writing fast timer holds count two cycles
// - watchdog timeout resets device, clears timeout status
// - watchdog runs on own rc clock
// - 18 ms base, postscaled up to 1:128
// - watchdog clear resets count and assigned prescaler
// - sleep resets watchdog and assigned prescaler
// - one shared down-counter, single owner
// - option bit 3 assigns, bits 2:0 ratio
// - fast timer write clears timer prescaler
// - prescaler hidden, all ones on reset
// - fast timer wrap sets overflow flag
// - period timer prescale 1,4,8,16
// - period prescaler cleared on count or control writes, reset
// - period timer counts zero to limit
// - match flag set on rollover
// - run bit gates counting and flag
// - period rollover drives serial bit clock
// - interrupt mask one enable per source
// - assign one to watchdog, zero fast
// - ratio doubles per step per owner
// - flags sticky until software write
`timescale 1ns/1ps
`default_nettype none
module twp_timer_unit
  import twp_pkg::*;
#(
  parameter int unsigned WDT_TIMEOUT_CYC = `TWP_WDT_TIMEOUT_US * `TWP_WDT_RC_KHZ / 1000
) (
  // clocks, reset, enable
  input  wire logic            i_clk_sys,
  input  wire logic            i_clk_rc,
  input  wire logic            i_reset_n,
  input  wire logic            i_ce,
  // special register port
  input  wire logic            i_reg_wr,
  input  wire logic [7:0]      i_reg_addr,
  input  wire twp_pkg::twp_byte_t i_reg_wdata,
  output twp_pkg::twp_byte_t   o_reg_rdata,
  // option register transfer
  input  wire logic            i_option_wr,
  output twp_pkg::twp_byte_t   o_option,
  // instructions
  input  wire logic            i_watchdog_clear_instr,
  input  wire logic            i_sleep_instr,
  // flag inputs from other sources
  input  wire logic [7:0]      i_ext_flag_set,
  // outputs
  output logic                 o_irq_req,
  output logic                 o_wdt_reset,
  output logic                 o_timeout_status,
  output logic                 o_serial_bit_clk
);
  import twp_pkg::*;

  // shared prescaler tap: ratio select, returns terminal mask
  // the fast timer owner sees one extra doubling, so code 0 divides by two
  // while the watchdog owner divides by one; one table serves both owners
  // and keeps the two ratio ladders from drifting apart
  function automatic logic [7:0] twp_tap(input logic [2:0] sel, input logic wdt);
    logic [3:0] sh;
    sh = wdt ? {1'b0, sel} : ({1'b0, sel} + 4'd1);
    twp_tap = 8'((9'h1 << sh) - 9'h1);
  endfunction

  // post-write inhibit length; the core expects the written value to survive
  // long enough to be read back unchanged
  localparam int unsigned HOLD = `TWP_FAST_HOLD_CYC;

  // software visible state
  twp_byte_t option_q;          // ratio and owner
  twp_byte_t power_control_q;            // power control
  twp_byte_t mask_q;            // interrupt mask
  twp_byte_t flag_q;            // interrupt flags
  // counters; the shared prescaler is never mapped for reading
  twp_byte_t fast_cnt_q;        // fast timer
  twp_byte_t pre_q;             // shared down-counter
  logic [1:0] hold_q;           // post-write inhibit
  twp_byte_t per_cnt_q;         // period timer
  twp_byte_t per_lim_q;         // period limit
  logic [2:0] per_ctl_q;        // run and prescale select
  logic [3:0] per_pre_q;        // period prescaler
  // watchdog crossing state; toggles survive any ratio of clock rates
  logic       wdt_clr_tgl_q;    // clear request toggle
  logic [2:0] tick_sync_q;      // timeout toggle sync
  logic       tick_tgl;         // from rc domain

  // combinational strobes
  logic       to_wdt;
  logic       fast_wr;
  logic       pre_clr;
  logic       pre_tc;
  logic       fast_inc;
  logic       fast_wrap;
  logic       wdt_event;
  logic       base_tick;
  logic       per_tick;
  logic       per_roll;
  logic [3:0] per_div;

  assign to_wdt   = option_q[`TWP_OPT_ASSIGN];
  assign fast_wr  = i_reg_wr && (i_reg_addr == `TWP_ADDR_FAST_CNT);
  // clear prescaler on owner's clear events; a reassignment relies on software clearing
  assign pre_clr  = to_wdt ? (i_watchdog_clear_instr || i_sleep_instr)
                           : fast_wr;
  assign base_tick = tick_sync_q[2] ^ tick_sync_q[1];
  // terminal count looks at the value after the decrement, so a freshly
  // cleared prescaler gives its owner the full ratio before the first step
  assign pre_tc   = ((pre_q - 8'h01) & twp_tap(option_q[2:0], to_wdt)) == 8'h00;
  assign fast_inc = (hold_q == 2'd0) && (to_wdt || pre_tc);
  // wrap only when the increment really lands; a same-cycle write wins
  assign fast_wrap = fast_inc && !fast_wr && (fast_cnt_q == 8'hff);
  // an enabled watchdog reset needs a base tick and, when postscaled, terminal count
  assign wdt_event = power_control_q[`TWP_POWER_CONTROL_WDT_EN] && base_tick && (!to_wdt || pre_tc);

  // watchdog in its own domain
  twp_wdt_core #(.TIMEOUT_CYC(WDT_TIMEOUT_CYC)) u_wdt (
    .i_clk_rc   (i_clk_rc),
    .i_reset_n  (i_reset_n),
    .i_enable   (power_control_q[`TWP_POWER_CONTROL_WDT_EN]),
    .i_clr_tgl  (wdt_clr_tgl_q),
    .o_tick_tgl (tick_tgl)
  );

  // latency of two to three cycles is small against any usable timeout
  // timeout toggle into system domain; first stage only feeds second
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      tick_sync_q <= 3'b000;
    end else begin
      tick_sync_q <= {tick_sync_q[1:0], tick_tgl};
    end
  end

  // a pulse could be missed by the slower rc clock, a toggle cannot
  // clear and sleep requests cross as a toggle
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      wdt_clr_tgl_q <= 1'b0;
    end else if (i_ce && (i_watchdog_clear_instr || i_sleep_instr)) begin
      wdt_clr_tgl_q <= ~wdt_clr_tgl_q;
    end
  end

  // option arrives on its own strobe, the rest through the register port
  // control registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      option_q  <= `TWP_OPTION_RST;
      power_control_q    <= `TWP_POWER_CONTROL_RST;
      mask_q    <= 8'h00;
      per_lim_q <= 8'hff;
      per_ctl_q <= 3'b000;
    end else if (i_ce) begin
      if (i_option_wr) begin
        option_q <= i_reg_wdata;
      end
      if (i_reg_wr) begin
        case (i_reg_addr)
          `TWP_ADDR_PWR_CTRL:  power_control_q    <= (i_reg_wdata & `TWP_POWER_CONTROL_RMASK) | `TWP_POWER_CONTROL_RST;
          `TWP_ADDR_IRQ_MASK:  mask_q    <= i_reg_wdata;
          `TWP_ADDR_PER_LIMIT: per_lim_q <= i_reg_wdata;
          `TWP_ADDR_PER_CTRL:  per_ctl_q <= i_reg_wdata[2:0];
          default: ;
        endcase
      end
    end
  end

  // the owner decides what makes it step; a clear always takes priority
  // shared down-counter, hidden from software
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      pre_q <= `TWP_PRESCALE_RST;
    end else if (i_ce) begin
      if (pre_clr) begin
        pre_q <= 8'h00;
      end else if (to_wdt ? (base_tick && power_control_q[`TWP_POWER_CONTROL_WDT_EN]) : (hold_q == 2'd0)) begin
        pre_q <= pre_q - 8'h01;
      end
    end
  end

  // the written value wins over an increment in the same cycle
  // fast timer and post-write inhibit
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      fast_cnt_q <= 8'h00;
      hold_q     <= 2'd0;
    end else if (i_ce) begin
      if (fast_wr) begin
        fast_cnt_q <= i_reg_wdata;
        hold_q     <= 2'(HOLD);
      end else begin
        if (hold_q != 2'd0) begin
          hold_q <= hold_q - 2'd1;
        end
        if (fast_inc) begin
          fast_cnt_q <= fast_cnt_q + 8'h01;
        end
      end
    end
  end

  // the stored value is the last count before a tick, so a tick every div+1 cycles
  // period timer prescaler select
  always_comb begin
    case (per_ctl_q[1:0])
      2'b00:   per_div = 4'd0;
      2'b01:   per_div = 4'd3;
      2'b10:   per_div = 4'd7;
      default: per_div = 4'd15;
    endcase
  end
  assign per_tick = per_ctl_q[`TWP_PER_RUN] && (per_pre_q >= per_div);
  assign per_roll = per_tick && (per_cnt_q == per_lim_q);

  // a write to the count or control register restarts the prescaler phase
  // period timer and its prescaler
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      per_pre_q <= 4'h0;
      per_cnt_q <= 8'h00;
    end else if (i_ce) begin
      if (i_reg_wr && (i_reg_addr == `TWP_ADDR_PER_CNT)) begin
        per_pre_q <= 4'h0;
        per_cnt_q <= i_reg_wdata;
      end else if (i_reg_wr && (i_reg_addr == `TWP_ADDR_PER_CTRL)) begin
        per_pre_q <= 4'h0;
      end else if (per_ctl_q[`TWP_PER_RUN]) begin
        per_pre_q <= per_tick ? 4'h0 : per_pre_q + 4'h1;
        if (per_tick) begin
          per_cnt_q <= per_roll ? 8'h00 : per_cnt_q + 8'h01;
        end
      end
    end
  end

  // bits of the other sources arrive as single-cycle set pulses
  // sticky flags; hardware set wins over a same-cycle write
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      flag_q <= 8'h00;
    end else if (i_ce) begin
      flag_q <= ((i_reg_wr && i_reg_addr == `TWP_ADDR_IRQ_FLAG) ? i_reg_wdata : flag_q)
                | i_ext_flag_set
                | {4'h0, per_roll, 2'b00, fast_wrap};
    end
  end

  // outputs, all registered
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_irq_req        <= 1'b0;
      o_wdt_reset      <= 1'b0;
      o_timeout_status <= 1'b1;
      o_serial_bit_clk <= 1'b0;
      o_option         <= `TWP_OPTION_RST;
      o_reg_rdata      <= 8'h00;
    end else if (i_ce) begin
      o_irq_req   <= |(flag_q & mask_q);
      o_wdt_reset <= wdt_event;
      if (wdt_event) begin
        o_timeout_status <= 1'b0;
      end else if (i_watchdog_clear_instr || i_sleep_instr) begin
        o_timeout_status <= 1'b1;
      end
      // serial bit clock is half the rollover rate, a clean even duty
      if (per_roll) begin
        o_serial_bit_clk <= ~o_serial_bit_clk;
      end
      o_option <= option_q;
      // read data follows the address one cycle late; unmapped reads give zero
      case (i_reg_addr)
        `TWP_ADDR_FAST_CNT:  o_reg_rdata <= fast_cnt_q;
        `TWP_ADDR_PER_CTRL:  o_reg_rdata <= {5'h00, per_ctl_q};
        `TWP_ADDR_PWR_CTRL:  o_reg_rdata <= power_control_q;
        `TWP_ADDR_IRQ_MASK:  o_reg_rdata <= mask_q;
        `TWP_ADDR_PER_CNT:   o_reg_rdata <= per_cnt_q;
        `TWP_ADDR_PER_LIMIT: o_reg_rdata <= per_lim_q;
        `TWP_ADDR_IRQ_FLAG:  o_reg_rdata <= flag_q;
        default:             o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // assertions guard the rules that tests reach only rarely
  // checks
  AST_HOLD_TWO: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && fast_wr) ##1 (i_ce && !fast_wr)[*2] |-> $stable(fast_cnt_q))
    else $error("fast timer moved during write hold");
  AST_FAST_FLAG: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && fast_inc && !fast_wr && fast_cnt_q == 8'hff) |=> flag_q[`TWP_FLAG_FAST])
    else $error("overflow flag missed");
  AST_PRE_RESET: assert property (@(posedge i_clk_sys)
    !i_reset_n |=> pre_q == 8'hff)
    else $error("prescaler not all ones after reset");
  AST_PRE_CLR: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && !to_wdt && fast_wr) |=> pre_q == 8'h00)
    else $error("prescaler not cleared on fast write");
  AST_PER_ROLL: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && per_roll && !i_reg_wr) |=> per_cnt_q == 8'h00 && flag_q[`TWP_FLAG_PERIOD])
    else $error("period rollover wrong");
  AST_PER_STOP: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !per_ctl_q[`TWP_PER_RUN] |-> !per_roll)
    else $error("stopped period timer rolled");
  AST_STICKY: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && flag_q[0] && !(i_reg_wr && i_reg_addr == `TWP_ADDR_IRQ_FLAG)) |=> flag_q[0])
    else $error("flag dropped without write");
  AST_IRQ: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && (flag_q & mask_q) == 8'h00) |=> !o_irq_req)
    else $error("irq without enabled flag");
  AST_WDT_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && !power_control_q[`TWP_POWER_CONTROL_WDT_EN]) |=> !o_wdt_reset)
    else $error("disabled watchdog fired");
  AST_TO_CLR: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && wdt_event) |=> (o_wdt_reset && !o_timeout_status))
    else $error("timeout without reset or status clear");
  // prescaler restart on period writes
  AST_PER_PRE_CLR: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && i_reg_wr &&
     (i_reg_addr == `TWP_ADDR_PER_CNT || i_reg_addr == `TWP_ADDR_PER_CTRL)) |=> per_pre_q == 4'h0)
    else $error("period prescaler not restarted");
  // owner clear paths of the shared prescaler
  AST_WDT_CLR_PRE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && to_wdt && i_watchdog_clear_instr) |=> pre_q == 8'h00)
    else $error("prescaler kept after watchdog clear");
  AST_SLEEP_PRE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && to_wdt && i_sleep_instr) |=> pre_q == 8'h00)
    else $error("prescaler kept after sleep");
  // unscaled fast timer steps once per cycle outside the hold
  AST_FAST_STEP: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && to_wdt && hold_q == 2'd0 && !fast_wr) |=> fast_cnt_q == $past(fast_cnt_q) + 8'h01)
    else $error("fast timer missed a step");
  // stopped period timer holds its count
  AST_PER_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_ce && !per_ctl_q[`TWP_PER_RUN] && !i_reg_wr) |=> $stable(per_cnt_q))
    else $error("stopped period timer moved");
endmodule
`default_nettype wire

// File: test/twp_timer_unit_bench.sv
/*
 * self-checking bench for the timer unit: registers, fast timer, shared prescaler,
 * period timer, interrupt mask and watchdog.
 * assumes twp_cfg.svh on the include path; bench drives every port itself.
 */
`timescale 1ns/1ps
`default_nettype none
`include "twp_cfg.svh"
module twp_timer_unit_bench;
  import twp_pkg::*;
  localparam int unsigned WD_CYC = 40;    // short watchdog base count
  localparam logic [7:0]  A_FAST = `TWP_ADDR_FAST_CNT;
  localparam logic [7:0]  A_PCTL = `TWP_ADDR_PER_CTRL;
  localparam logic [7:0]  A_PWR  = `TWP_ADDR_PWR_CTRL;
  localparam logic [7:0]  A_MASK = `TWP_ADDR_IRQ_MASK;
  localparam logic [7:0]  A_PCNT = `TWP_ADDR_PER_CNT;
  localparam logic [7:0]  A_PLIM = `TWP_ADDR_PER_LIMIT;
  localparam logic [7:0]  A_FLAG = `TWP_ADDR_IRQ_FLAG;
  // stimulus
  logic       clk_sys   = 1'b0;
  logic       clk_rc    = 1'b0;
  logic       reset_n   = 1'b0;
  logic       reg_wr    = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  twp_byte_t  reg_wdata = 8'h00;
  logic       option_wr = 1'b0;
  logic       wd_clr    = 1'b0;
  logic       sleep     = 1'b0;
  logic [7:0] ext_set   = 8'h00;
  // observed
  twp_byte_t  reg_rdata;
  twp_byte_t  option;
  logic       irq;
  logic       wdt_rst;
  logic       to_stat;
  logic       ser_clk;
  int         n_mismatch = 0;
  int         cmp_count  = 0;
  // rc period chosen unrelated to the 50 ns system clock
  always #25 clk_sys = ~clk_sys;
  always #115 clk_rc = ~clk_rc;
  twp_timer_unit #(.WDT_TIMEOUT_CYC(WD_CYC)) dut (
    .i_clk_sys(clk_sys), .i_clk_rc(clk_rc), .i_reset_n(reset_n), .i_ce(1'b1),
    .i_reg_wr(reg_wr), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(reg_rdata), .i_option_wr(option_wr), .o_option(option),
    .i_watchdog_clear_instr(wd_clr), .i_sleep_instr(sleep), .i_ext_flag_set(ext_set),
    .o_irq_req(irq), .o_wdt_reset(wdt_rst), .o_timeout_status(to_stat),
    .o_serial_bit_clk(ser_clk));
  // verdict, reached from the main sequence or a timeout
  task automatic end_of_test();
    $display("counts: %0d compared, %0d mismatched", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic tmo(input string what);
    n_mismatch++;
    $display("mismatch %s expected event seen timeout", what);
    end_of_test();
  endtask
  // register port cycles, strobe held for exactly one taken edge
  task automatic wr(input logic [7:0] a, input twp_byte_t d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic opt(input twp_byte_t d);
    @(posedge clk_sys);
    option_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk_sys);
    option_wr <= 1'b0;
  endtask
  // read data trails the address by one cycle; one extra for margin
  task automatic rd(input logic [7:0] a, output twp_byte_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask
  task automatic nxt(output twp_byte_t v);
    @(posedge clk_sys);
    #1 v = reg_rdata;
  endtask
  task automatic instr(input bit slp);
    @(posedge clk_sys);
    if (slp) sleep <= 1'b1;
    else wd_clr <= 1'b1;
    @(posedge clk_sys);
    sleep  <= 1'b0;
    wd_clr <= 1'b0;
  endtask
  function automatic logic [7:0] smp(input bit sel);
    return sel ? {7'h00, ser_clk} : reg_rdata;
  endfunction
  // cycles between two successive changes of read data or serial clock
  task automatic gap(input bit sel, output int n);
    logic [7:0] a;
    logic [7:0] b;
    int         k;
    k = 0;
    n = 0;
    @(posedge clk_sys);
    #1 a = smp(sel);
    b = a;
    while (b === a) begin
      @(posedge clk_sys);
      #1 b = smp(sel);
      k++;
      if (k > 600) tmo("first step");
    end
    a = b;
    while (b === a) begin
      @(posedge clk_sys);
      #1 b = smp(sel);
      n++;
      if (n > 600) tmo("next step");
    end
  endtask
  task automatic wt(output int n);
    n = 0;
    while (wdt_rst !== 1'b1) begin
      @(posedge clk_sys);
      #1 n++;
      if (n > 2000) tmo("watchdog reset");
    end
  endtask
  task automatic quiet(input int cyc, inout int hits);
    repeat (cyc) begin
      @(posedge clk_sys);
      #1 if (wdt_rst !== 1'b0) hits++;
    end
  endtask
  task automatic t_reset();
    twp_byte_t v;
    chk("option reset", `TWP_OPTION_RST, option);
    chk("timeout status reset", 8'h01, {7'h00, to_stat});
    rd(A_MASK, v);
    chk("mask reset", 8'h00, v);
    wr(8'h20, 8'hff);
    rd(8'h20, v);
    chk("unmapped read", 8'h00, v);
    $display("test reset done");
  endtask
  // write holds the count for two cycles, then one step a cycle
  task automatic t_fast();
    twp_byte_t s [12];
    int        n5;
    int        last;
    n5 = 0;
    last = 0;
    opt(8'h08);
    wr(A_FAST, 8'h80);
    repeat (4) @(posedge clk_sys);
    wr(A_FAST, 8'h05);
    for (int i = 0; i < 12; i++) nxt(s[i]);
    for (int i = 0; i < 10; i++) if (s[i] === 8'h05) begin
      n5++;
      last = i;
    end
    chk("held samples", 8'h03, 8'(n5));
    chk("first step", 8'h06, s[last+1]);
    chk("second step", 8'h07, s[last+2]);
    $display("test fast done");
  endtask
  task automatic t_over();
    twp_byte_t v;
    wr(A_MASK, 8'h01);
    wr(A_FLAG, 8'h00);
    wr(A_FAST, 8'hfd);
    repeat (12) @(posedge clk_sys);
    rd(A_FLAG, v);
    chk("overflow flag", 8'h01, v);
    chk("irq enabled", 8'h01, {7'h00, irq});
    wr(A_MASK, 8'h00);
    repeat (3) @(posedge clk_sys);
    #1 chk("irq masked", 8'h00, {7'h00, irq});
    rd(A_FLAG, v);
    chk("flag sticky", 8'h01, v);
    wr(A_FLAG, 8'h00);
    rd(A_FLAG, v);
    chk("flag cleared", 8'h00, v);
    $display("test overflow done");
  endtask
  // every other source bit gated by its own enable only
  task automatic t_ext();
    twp_byte_t v;
    logic [7:0] b;
    for (int i = 0; i < 8; i++) begin
      if (i == 0 || i == 3) continue;
      b = 8'h01 << i;
      wr(A_FLAG, 8'h00);
      @(posedge clk_sys);
      ext_set <= b;
      @(posedge clk_sys);
      ext_set <= 8'h00;
      wr(A_MASK, ~b & 8'hf6);
      repeat (3) @(posedge clk_sys);
      #1 chk("irq other masks", 8'h00, {7'h00, irq});
      wr(A_MASK, b);
      repeat (3) @(posedge clk_sys);
      #1 chk("irq own mask", 8'h01, {7'h00, irq});
      rd(A_MASK, v);
      chk("mask readback", b, v);
    end
    wr(A_MASK, 8'h00);
    $display("test mask done");
  endtask
  task automatic t_pre();
    int n;
    for (int r = 0; r < 3; r++) begin
      opt(8'(r));
      wr(A_FAST, 8'h00);
      gap(1'b0, n);
      chk_rng("prescaled step", 2 << r, 2 << r, n);
    end
    chk("option readback", 8'h02, option);
    $display("test prescaler done");
  endtask
  task automatic t_period();
    twp_byte_t v;
    twp_byte_t hi;
    twp_byte_t lo;
    int        n;
    wr(A_PLIM, 8'h03);
    wr(A_PCNT, 8'h00);
    wr(A_PCTL, 8'h04);
    rd(A_PCNT, v);
    hi = 8'h00;
    lo = 8'hff;
    repeat (16) begin
      nxt(v);
      if (v > hi) hi = v;
      if (v < lo) lo = v;
    end
    chk("count top", 8'h03, hi);
    chk("count bottom", 8'h00, lo);
    for (int p = 0; p < 4; p++) begin
      wr(A_PCTL, 8'h04 | 8'(p));
      gap(1'b1, n);
      chk_rng("rollover gap", 4 * (p == 0 ? 1 : 2 << p), 4 * (p == 0 ? 1 : 2 << p), n);
    end
    rd(A_FLAG, v);
    chk("match flag", 8'h08, v & 8'h08);
    wr(A_PCTL, 8'h00);
    wr(A_FLAG, 8'h00);
    repeat (100) @(posedge clk_sys);
    rd(A_FLAG, v);
    chk("stopped flag", 8'h00, v & 8'h08);
    $display("test period done");
  endtask
  // ranges allow for the clear and timeout crossings between clocks
  task automatic t_wdt();
    int n;
    int h;
    h = 0;
    opt(8'h08);
    wr(A_PWR, 8'h20);
    instr(1'b0);
    wt(n);
    chk_rng("timeout 1:1", 150, 260, n);
    repeat (3) @(posedge clk_sys);
    #1 chk("timeout status", 8'h00, {7'h00, to_stat});
    opt(8'h09);
    wr(A_PWR, 8'h20);
    instr(1'b0);
    wt(n);
    chk_rng("timeout 1:2", 300, 460, n);
    opt(8'h08);
    wr(A_PWR, 8'h20);
    repeat (6) begin
      instr(1'b0);
      quiet(100, h);
    end
    chk_rng("cleared watchdog", 0, 0, h);
    quiet(50, h);
    instr(1'b1);
    repeat (3) @(posedge clk_sys);
    #1 chk("status after sleep", 8'h01, {7'h00, to_stat});
    wt(n);
    chk_rng("sleep timeout", 145, 260, n);
    wr(A_PWR, 8'h00);
    instr(1'b0);
    quiet(800, h);
    chk_rng("disabled watchdog", 0, 0, h);
    $display("test watchdog done");
  endtask
  initial begin
    // reset long enough to span three rc edges
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_fast();
    t_over();
    t_ext();
    t_pre();
    t_period();
    t_wdt();
    end_of_test();
  end
endmodule
`default_nettype wire
